// File: src/pcc_cfg.svh
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH

// ==========================================================================
// Register byte offsets
`define PCC_OFS_PIN_REPL 8'h00
`define PCC_OFS_FUNC_CTRL 8'h04
`define PCC_OFS_STRAP_STAT 8'h08
`define PCC_OFS_CORE_STAT 8'h0c

// ==========================================================================
// Field positions
`define PCC_RDY_BIT 0
`define PCC_LAN_EN_BIT 0
`define PCC_MODEM_EN_BIT 1
`define PCC_INT_SEL_BIT 2
`define PCC_STRAP_IO_DIS_BIT 0
`define PCC_STRAP_MWE_BIT 2

// ==========================================================================
// Reset values
`define PCC_FUNC_CTRL_RST 3'h1
`define PCC_STRAP_RST 9'h000
`define PCC_STROBE_IDLE 6'h3f

// ==========================================================================
// Bus responses
`define PCC_RESP_OKAY 2'h0
`define PCC_RESP_DECERR 2'h3

`endif

// File: src/pcc_pkg.sv
package pcc_pkg;

  typedef enum logic [1:0] {
    PCC_IDLE = 2'h0,
    PCC_ISSUE = 2'h1,
    PCC_HOLD = 2'h3
  } pcc_state_type;

  typedef enum logic [1:0] {
    PCC_SP_ATTR = 2'h0,
    PCC_SP_COMMON = 2'h1,
    PCC_SP_IOREG = 2'h2,
    PCC_SP_DMA = 2'h3
  } pcc_space_type;

  typedef struct packed {
    logic ce1_n;
    logic reg_n;
    logic oe_n;
    logic we_n;
    logic ior_n;
    logic iow_n;
  } pcc_strobe_type;

  typedef struct packed {
    logic valid;
    pcc_space_type space;
    logic write;
    logic wide;
    logic [9:0] addr;
    logic [15:0] wdata;
  } pcc_req_type;

endpackage

// File: src/pcc_sync.sv
`timescale 1ns/10ps
`include "pcc_cfg.svh"

module pcc_sync import pcc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input pcc_strobe_type i_async,
  output pcc_strobe_type o_sync
);

  // ========================================================================
  // Two flops; first stage feeds only the second
  pcc_strobe_type meta_q;
  pcc_strobe_type sync_q;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      meta_q <= pcc_strobe_type'(`PCC_STROBE_IDLE);
      sync_q <= pcc_strobe_type'(`PCC_STROBE_IDLE);
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

// File: src/pcc_host_if.sv
`timescale 1ns/10ps
`include "pcc_cfg.svh"

module pcc_host_if import pcc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  // Host socket side
  input wire logic i_host_rst,
  input wire logic [8:0] i_config_strap,
  input wire logic [9:0] i_host_address_lines,
  input wire logic [15:0] i_host_data_lines,
  output logic [15:0] o_host_data_lines,
  output logic [1:0] o_host_data_oe,
  input wire logic i_ce1_n,
  input wire logic i_reg_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  output logic o_reset_out_n,
  output logic o_wait_n,
  output logic o_inpack_n,
  output logic o_io16_n,
  output logic o_int_rdy_n,
  // Core side
  output pcc_req_type o_core_req,
  input wire logic i_core_ack,
  input wire logic [15:0] i_core_rdata,
  input wire logic i_dma_active,
  input wire logic i_core_ready,
  input wire logic i_lan_irq,
  input wire logic i_modem_irq,
  // AXI4-Lite slave
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);

  // ========================================================================
  // Helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `PCC_OFS_PIN_REPL) | hit(a, `PCC_OFS_FUNC_CTRL) |
             hit(a, `PCC_OFS_STRAP_STAT) | hit(a, `PCC_OFS_CORE_STAT);
  endfunction

  // ========================================================================
  // Reset and straps
  logic host_rst_q;
  logic [8:0] strap_q;
  logic reset_out_n_q;
  wire logic core_rst = ~i_rstn | i_host_rst;
  wire logic host_rst_fall = host_rst_q & ~i_host_rst;
  wire logic io_mode = ~strap_q[`PCC_STRAP_IO_DIS_BIT];
  wire logic mem_wr_en = strap_q[`PCC_STRAP_MWE_BIT];

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      host_rst_q <= 1'b1;
      strap_q <= `PCC_STRAP_RST;
      reset_out_n_q <= 1'b0;
    end else begin
      host_rst_q <= i_host_rst;
      reset_out_n_q <= ~i_host_rst;
      if (host_rst_fall) begin
        strap_q <= i_config_strap;
      end
    end
  end

  // ========================================================================
  // Strobe synchroniser
  pcc_strobe_type strobe_raw;
  pcc_strobe_type s;

  assign strobe_raw = '{ce1_n: i_ce1_n, reg_n: i_reg_n, oe_n: i_oe_n,
                        we_n: i_we_n, ior_n: i_ior_n, iow_n: i_iow_n};

  pcc_sync u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(strobe_raw),
    .o_sync(s)
  );

  // ========================================================================
  // Strobe decode
  wire logic sel = ~s.ce1_n;
  wire logic mem_rd = sel & ~s.oe_n;
  wire logic mem_wr = sel & ~s.we_n & (s.reg_n | mem_wr_en);
  // I/O with REG high is not for this card
  wire logic io_rd = sel & ~s.reg_n & ~s.ior_n;
  wire logic io_wr = sel & ~s.reg_n & ~s.iow_n;
  wire logic any_strobe = sel & ~(s.oe_n & s.we_n & s.ior_n & s.iow_n);
  wire logic is_io = io_rd | io_wr;
  wire logic start = mem_rd | mem_wr | is_io;
  wire logic dma_cyc = is_io & i_dma_active;
  wire pcc_space_type space =
    is_io ? (i_dma_active ? PCC_SP_DMA : PCC_SP_IOREG) :
    (s.reg_n ? PCC_SP_COMMON : PCC_SP_ATTR);

  // ========================================================================
  // Access sequencer
  pcc_state_type state_q;
  pcc_state_type state_d;
  pcc_req_type req_q;
  logic [15:0] rdata_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PCC_IDLE: begin
        if (start) begin
          state_d = PCC_ISSUE;
        end
      end
      PCC_ISSUE: begin
        if (i_core_ack) begin
          state_d = PCC_HOLD;
        end
      end
      PCC_HOLD: begin
        // Wait for release so one strobe gives one action
        if (!any_strobe) begin
          state_d = PCC_IDLE;
        end
      end
      default: begin
        state_d = PCC_IDLE;
      end
    endcase
  end

  wire logic take = (state_q == PCC_IDLE) & start;
  wire logic cur_io = (req_q.space == PCC_SP_IOREG) |
                      (req_q.space == PCC_SP_DMA);
  wire logic cur_dma = req_q.space == PCC_SP_DMA;
  wire logic busy_d = state_d != PCC_IDLE;
  wire logic rd_d = busy_d & ~req_q.write & any_strobe;

  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      state_q <= PCC_IDLE;
      req_q <= '0;
      rdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (take) begin
        req_q.valid <= 1'b1;
        req_q.space <= space;
        req_q.write <= mem_wr | io_wr;
        req_q.wide <= dma_cyc;
        req_q.addr <= i_host_address_lines;
        req_q.wdata <= i_host_data_lines;
      end else if ((state_q == PCC_ISSUE) & i_core_ack) begin
        req_q.valid <= 1'b0;
        rdata_q <= i_core_rdata;
      end
    end
  end

  // ========================================================================
  // Host response pins
  logic wait_n_q;
  logic inpack_n_q;
  logic io16_n_q;
  logic [1:0] data_oe_q;
  logic int_rdy_n_q;
  logic rdy_q;
  logic [2:0] func_ctrl_q;

  wire logic next_dma = take ? dma_cyc : cur_dma;
  wire logic next_io = take ? is_io : cur_io;
  wire logic next_rd = take ? (mem_rd | io_rd) : rd_d;
  wire logic lan_en = func_ctrl_q[`PCC_LAN_EN_BIT];
  wire logic modem_en = func_ctrl_q[`PCC_MODEM_EN_BIT];
  wire logic int_sel = func_ctrl_q[`PCC_INT_SEL_BIT];
  wire logic irq_any = int_sel ? (lan_en & i_lan_irq) :
    ((lan_en & i_lan_irq) | (modem_en & i_modem_irq));

  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      wait_n_q <= 1'b1;
      inpack_n_q <= 1'b1;
      io16_n_q <= 1'b1;
      data_oe_q <= 2'h0;
      int_rdy_n_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= i_core_ready;
      // Stretch DMA cycles until the core acknowledges
      wait_n_q <= ~(state_d == PCC_ISSUE & next_dma);
      inpack_n_q <= ~(busy_d & next_io & next_rd);
      io16_n_q <= ~(busy_d & next_dma);
      // Data only after the core answered
      data_oe_q <= (state_d == PCC_HOLD & rd_d) ?
                   {req_q.wide, 1'b1} : 2'h0;
      if (io_mode) begin
        int_rdy_n_q <= ~irq_any;
      end else begin
        int_rdy_n_q <= i_core_ready;
      end
    end
  end

  assign o_host_data_lines = rdata_q;
  assign o_host_data_oe = data_oe_q;
  assign o_reset_out_n = reset_out_n_q;
  assign o_wait_n = wait_n_q;
  assign o_inpack_n = inpack_n_q;
  assign o_io16_n = io16_n_q;
  assign o_int_rdy_n = int_rdy_n_q;
  assign o_core_req = req_q;

  // ========================================================================
  // AXI4-Lite write path
  logic awready_q;
  logic wready_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  wire logic aw_hs = i_s_axi_awvalid & awready_q;
  wire logic w_hs = i_s_axi_wvalid & wready_q;
  wire logic commit = aw_have_q & w_have_q & ~bvalid_q;
  wire logic fc_wr = commit & hit(awaddr_q, `PCC_OFS_FUNC_CTRL) &
                     wstrb_q[0];

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `PCC_RESP_OKAY;
    end else begin
      awready_q <= i_s_axi_awvalid & ~awready_q & ~aw_have_q & ~bvalid_q;
      wready_q <= i_s_axi_wvalid & ~wready_q & ~w_have_q & ~bvalid_q;
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        awaddr_q <= i_s_axi_awaddr;
      end else if (commit) begin
        aw_have_q <= 1'b0;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
      end else if (commit) begin
        w_have_q <= 1'b0;
      end
      if (commit) begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? `PCC_RESP_OKAY : `PCC_RESP_DECERR;
      end else if (i_s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Function control survives host reset only via software rewrite
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      func_ctrl_q <= `PCC_FUNC_CTRL_RST;
    end else if (fc_wr) begin
      func_ctrl_q <= wdata_q[2:0];
    end
  end

  // ========================================================================
  // AXI4-Lite read path
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_axi_q;
  logic [1:0] rresp_q;

  wire logic ar_hs = i_s_axi_arvalid & arready_q;
  wire logic [7:0] ra = i_s_axi_araddr;
  wire logic [31:0] rd_mux =
    hit(ra, `PCC_OFS_PIN_REPL) ? {31'h0, rdy_q} :
    hit(ra, `PCC_OFS_FUNC_CTRL) ? {29'h0, func_ctrl_q} :
    hit(ra, `PCC_OFS_STRAP_STAT) ? {23'h0, strap_q} :
    hit(ra, `PCC_OFS_CORE_STAT) ?
      {28'h0, state_q, io_mode, host_rst_q} : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_axi_q <= 32'h0000_0000;
      rresp_q <= `PCC_RESP_OKAY;
    end else begin
      arready_q <= i_s_axi_arvalid & ~arready_q & ~rvalid_q;
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_axi_q <= rd_mux;
        rresp_q <= mapped(ra) ? `PCC_RESP_OKAY : `PCC_RESP_DECERR;
      end else if (i_s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready = wready_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_axi_q;
  assign o_s_axi_rresp = rresp_q;

endmodule

// File: dv/pcc_host_if_monitor.sv
`timescale 1ns/10ps
module pcc_host_if_monitor import pcc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_host_rst,
  input wire logic [8:0] i_config_strap,
  input wire logic i_ce1_n,
  input wire logic i_reg_n,
  input wire logic i_oe_n,
  input wire logic i_ior_n,
  input wire logic i_core_ack,
  input wire logic i_core_ready,
  input wire logic [1:0] o_host_data_oe,
  input wire logic o_reset_out_n,
  input wire logic o_wait_n,
  input wire logic o_inpack_n,
  input wire logic o_io16_n,
  input wire logic o_int_rdy_n,
  input pcc_req_type o_core_req
);
  // =====
  // Settle count, straps need a few edges
  logic [2:0] up_q;
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_host_rst) up_q <= 3'h0;
    else if (up_q != 3'h4) up_q <= up_q + 3'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  chk_reset_inverse: assert property (
    $past(i_rstn) |-> o_reset_out_n == !$past(i_host_rst))
    else $error("reset output not inverse of host reset");
  chk_wait_dma: assert property (
    !o_wait_n |-> !o_io16_n && o_core_req.valid)
    else $error("wait low outside pending dma cycle");
  chk_ack_release: assert property (
    o_core_req.valid && i_core_ack |=> o_wait_n && !o_core_req.valid)
    else $error("wait or request held after ack");
  chk_read_space: assert property (
    $rose(o_core_req.valid) && $past(!i_oe_n, 2) |-> !o_core_req.write &&
    o_core_req.space == ($past(i_reg_n, 2) ? PCC_SP_COMMON : PCC_SP_ATTR))
    else $error("memory read went to wrong space");
  chk_attr_write: assert property (
    $rose(o_core_req.valid) && o_core_req.write &&
    o_core_req.space == PCC_SP_ATTR |-> i_config_strap[2])
    else $error("attribute write without enable strap");
  chk_lane_width: assert property (
    |o_host_data_oe && !o_inpack_n |->
    o_host_data_oe == (o_io16_n ? 2'h1 : 2'h3))
    else $error("wrong data lanes driven");
  chk_inpack_read: assert property (
    $fell(o_inpack_n) |-> $past(!i_ior_n, 2) && $past(!i_reg_n, 2))
    else $error("inpack without io read");
  chk_io16_dma: assert property (
    $fell(o_io16_n) |-> o_core_req.valid && o_core_req.wide &&
    o_core_req.space == PCC_SP_DMA)
    else $error("io16 low outside dma cycle");
  chk_ready_pin: assert property (
    up_q == 3'h4 && i_config_strap[0] |->
    o_int_rdy_n == $past(i_core_ready))
    else $error("ready pin does not follow core");
  chk_card_select: assert property (
    $rose(o_core_req.valid) |-> $past(!i_ce1_n, 2))
    else $error("request without card enable");
endmodule

bind pcc_host_if pcc_host_if_monitor mon (.*);

// File: dv/pcc_host_model.sv
`timescale 1ns/10ps
module pcc_host_model import pcc_pkg::*; (
  input wire logic i_clk,
  input wire logic [15:0] i_data,
  input wire logic [1:0] i_data_oe,
  input wire logic i_wait_n,
  input wire logic i_inpack_n,
  input wire logic i_io16_n,
  output pcc_strobe_type o_strb,
  output logic [9:0] o_addr,
  output logic [15:0] o_data
);
  logic [15:0] rd_q = 16'h0;
  logic [2:0] seen_q = 3'h0;
  initial begin
    o_strb = 6'h3f;
    o_addr = 10'h0;
    o_data = 16'h0;
  end
  // =====
  // One socket cycle, stretched while wait is low
  task automatic cycle(input logic [5:0] s, input logic [9:0] a,
      input logic [15:0] d);
    int i;
    rd_q = 16'h0;
    seen_q = 3'h0;
    @(posedge i_clk);
    o_strb <= s;
    o_addr <= a;
    o_data <= d;
    for (i = 0; i < 60; i++) begin
      @(posedge i_clk);
      if (|i_data_oe) rd_q = i_data;
      seen_q = seen_q | {!i_wait_n, !i_io16_n, !i_inpack_n};
      if (i >= 10 && i_wait_n) break;
    end
    o_strb <= 6'h3f;
    // Released lines flip so stale values never match
    o_addr <= ~a;
    o_data <= ~d;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/10ps
`include "pcc_cfg.svh"
module testbench import pcc_pkg::*;;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_host_rst = 1'b1;
  logic [8:0] i_config_strap = 9'h004;
  logic [9:0] i_host_address_lines;
  logic [15:0] i_host_data_lines, o_host_data_lines, i_core_rdata = 16'h0;
  logic [1:0] o_host_data_oe, o_s_axi_bresp, o_s_axi_rresp;
  logic i_ce1_n, i_reg_n, i_oe_n, i_we_n, i_ior_n, i_iow_n;
  logic o_reset_out_n, o_wait_n, o_inpack_n, o_io16_n, o_int_rdy_n;
  pcc_req_type o_core_req, last_q;
  pcc_strobe_type strb;
  logic i_core_ack = 0, i_dma_active = 0, i_core_ready = 1;
  logic i_lan_irq = 0, i_modem_irq = 0;
  logic [7:0] i_s_axi_awaddr = 8'h0, i_s_axi_araddr = 8'h0;
  logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  logic i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] ok = `PCC_RESP_OKAY, de = `PCC_RESP_DECERR;
  int comparisons = 0, miscompares = 0, nreq = 0, cnt = 0;

  always #5 i_clk = ~i_clk;
  assign {i_ce1_n, i_reg_n, i_oe_n, i_we_n, i_ior_n, i_iow_n} = strb;
  pcc_host_if uut (.*);
  pcc_host_model host (.i_clk(i_clk), .i_data(o_host_data_lines),
    .i_data_oe(o_host_data_oe), .i_wait_n(o_wait_n),
    .i_inpack_n(o_inpack_n), .i_io16_n(o_io16_n), .o_strb(strb),
    .o_addr(i_host_address_lines), .o_data(i_host_data_lines));

  // =====
  // Core side: slow ack so wait states show
  always @(posedge i_clk) begin
    i_core_ack <= 1'b0;
    if (o_core_req.valid && !i_core_ack) begin
      cnt <= (cnt == 3) ? 0 : cnt + 1;
      if (cnt == 3) begin
        i_core_ack <= 1'b1;
        last_q <= o_core_req;
        nreq <= nreq + 1;
      end
      i_core_rdata <= {6'h2a, o_core_req.addr};
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
    int n;
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !(i_s_axi_bready && o_s_axi_bvalid); n++) begin
      @(posedge i_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end
    i_s_axi_bready <= 1'b0;
    // A write that never got its response is a failure
    chk(n >= 50, 1'b0);
    chk(o_s_axi_bresp, r);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] r);
    int n;
    @(posedge i_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !(i_s_axi_rready && o_s_axi_rvalid); n++) begin
      @(posedge i_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end
    i_s_axi_rready <= 1'b0;
    chk(n >= 50, 1'b0);
    chk(o_s_axi_rdata, e);
    chk(o_s_axi_rresp, r);
  endtask

  // Host cycle; ex is {space, write, wide}, es is {wait, io16, inpack}
  task automatic hc(input logic [5:0] s, input logic dm, input logic v,
      input logic [3:0] ex, input logic [9:0] a, input logic [2:0] es);
    int n0;
    logic [15:0] m;
    n0 = nreq;
    m = ex[0] ? 16'hffff : 16'h00ff;
    i_dma_active <= dm;
    host.cycle(s, a, 16'hc3a5);
    chk(nreq - n0, v);
    chk(host.seen_q, es);
    chk(o_wait_n, 1'b1);
    if (v) chk({last_q.space, last_q.write, last_q.wide, last_q.addr},
      {ex, a});
    if (v && ex[1]) chk(last_q.wdata & m, 16'hc3a5 & m);
    if (!ex[1]) chk(host.rd_q & m, v ? {6'h2a, a} & m : 16'h0);
  endtask

  task automatic hreset(input logic [8:0] st);
    i_host_rst <= 1'b1;
    i_config_strap <= st;
    repeat (3) @(posedge i_clk);
    i_host_rst <= 1'b0;
    repeat (5) @(posedge i_clk);
  endtask

  task automatic irq(input logic [2:0] v, input logic e);
    {i_core_ready, i_lan_irq, i_modem_irq} <= v;
    repeat (3) @(posedge i_clk);
    chk(o_int_rdy_n, e);
  endtask

  task automatic results();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // =====
  // Hang guard, far beyond the few hundred cycles used
  initial begin
    #300000;
    miscompares++;
    results();
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(o_reset_out_n, 1'b0);
    i_host_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk(o_reset_out_n, 1'b1);
    axr(8'h08, 32'h4, ok);
    axr(8'h04, 32'h1, ok);
    axr(8'h10, 32'h0, de);
    axw(8'h10, 32'hff, de);
    axw(8'h08, 32'h1ff, ok);
    axr(8'h08, 32'h4, ok);
    $display("registers done");
    // Strobe order is {ce1, reg, oe, we, ior, iow}, all active low
    hc(6'b000111, 0, 1, 4'h0, 10'h3c2, 3'h0);
    hc(6'b010111, 0, 1, 4'h4, 10'h201, 3'h0);
    hc(6'b011011, 0, 1, 4'h6, 10'h0f0, 3'h0);
    hc(6'b001011, 0, 1, 4'h2, 10'h10e, 3'h0);
    hc(6'b001101, 0, 1, 4'h8, 10'h01a, 3'h1);
    hc(6'b001110, 0, 1, 4'ha, 10'h01b, 3'h0);
    hc(6'b001101, 1, 1, 4'hd, 10'h010, 3'h7);
    hc(6'b001110, 1, 1, 4'hf, 10'h010, 3'h6);
    hc(6'b011101, 0, 0, 4'h0, 10'h01a, 3'h0);
    hc(6'b101011, 0, 0, 4'h0, 10'h2aa, 3'h0);
    $display("host cycles done");
    hreset(9'h001);
    axr(8'h08, 32'h1, ok);
    hc(6'b001011, 0, 0, 4'h0, 10'h020, 3'h0);
    irq(3'b000, 1'b0);
    axr(8'h00, 32'h0, ok);
    irq(3'b100, 1'b1);
    axr(8'h00, 32'h1, ok);
    $display("memory mode done");
    hreset(9'h004);
    axr(8'h04, 32'h1, ok);
    axw(8'h04, 32'h3, ok);
    irq(3'b110, 1'b0);
    irq(3'b101, 1'b0);
    irq(3'b100, 1'b1);
    axw(8'h04, 32'h7, ok);
    irq(3'b101, 1'b1);
    irq(3'b110, 1'b0);
    $display("interrupt done");
    results();
  end
endmodule
